// ---- pkg/pmcc_pkg.sv ----
// Constants and types shared by the power mode and clock control block
package pmcc_pkg;
    // Power states of the controller
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_SLEEP = 3'h1,
        ST_STOP = 3'h2,
        ST_STOP_WAKE = 3'h3,
        ST_STANDBY = 3'h4
    } pmcc_state_t;

    // Low-power mode select encoding
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_STOP = 2'h1;
    localparam logic [1:0] MODE_STANDBY = 2'h2;

    // Clock source encoding
    localparam logic [1:0] SRC_RC = 2'h0;
    localparam logic [1:0] SRC_XTAL = 2'h1;
    localparam logic [1:0] SRC_PLL = 2'h2;

    // Boot source encoding
    localparam logic [1:0] BOOT_FLASH = 2'h0;
    localparam logic [1:0] BOOT_SYSMEM = 2'h1;
    localparam logic [1:0] BOOT_SRAM = 2'h2;

    // Bus domain limit, prescaler widths and input line counts
    localparam int BUS_MAX_MHZ = 48;
    localparam int PRE_W = 4;
    localparam int EXT_LINES = 16;
    localparam int WAKE_PINS = 2;

    // Clock monitor window: time in ns and derived cycles at 8 ns
    localparam int CLK_PERIOD_NS = 8;
    localparam int MON_WINDOW_NS = 1000;
    localparam int MON_WINDOW_CYC = MON_WINDOW_NS / CLK_PERIOD_NS;
    localparam int MON_CNT_W = 8;
    // Regulator settle time before clock delivery, least time rounded up
    localparam int REG_SETTLE_NS = 100;
    localparam int REG_SETTLE_CYC =
        (REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SET_CNT_W = 5;
endpackage

// ---- verilog/pmcc_clk_monitor.sv ----
// Watches a synchronised external clock level for missing edges
`timescale 1ns/1ns
`default_nettype none
module pmcc_clk_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic enable,
    input wire logic ext_clk_sync,
    output logic fail
);
    logic prev_q;
    logic prev_d;
    logic [pmcc_pkg::MON_CNT_W-1:0] cnt_q;
    logic [pmcc_pkg::MON_CNT_W-1:0] cnt_d;
    logic fail_q;
    logic fail_d;

    // Counts cycles without an edge; fails when the window runs out
    always_comb
    begin
        prev_d = ext_clk_sync;
        cnt_d = cnt_q;
        fail_d = 1'b0;
        if (!enable || prev_q != ext_clk_sync)
        begin
            cnt_d = '0;
        end
        else if (cnt_q == pmcc_pkg::MON_CNT_W'(pmcc_pkg::MON_WINDOW_CYC - 1))
        begin
            fail_d = 1'b1;
            cnt_d = '0;
        end
        else
        begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    // State registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            prev_q <= 1'b0;
            cnt_q <= '0;
            fail_q <= 1'b0;
        end
        else if (ce)
        begin
            prev_q <= prev_d;
            cnt_q <= cnt_d;
            fail_q <= fail_d;
        end
    end

    assign fail = fail_q;
endmodule
`default_nettype wire

// ---- verilog/pmcc_top.sv ----
// Power mode sequencer and system clock control
// Functional notes
// - Sleep stops CPU clock; any interrupt resumes
// - Stop gates core clocks, oscillators, PLL off; RC stays on while rc_to_periph
// - Stop regulator mode is software selectable
// - Any external event line ends Stop
// - Regulator normal before RC clock to peripheral
// - Standby switches regulator and oscillators off
// - Reset pin, watchdog, wake edge, RTC exit Standby
// - RTC and watchdog clocks never stopped
// - Internal RC is clock after reset
// - Failed external clock falls back to RC
// - Failure interrupt only when enabled
// - Prescalers keep bus clocks within 48 MHz
// - Boot pin and option bit choose boot
`timescale 1ns/1ns
`default_nettype none
module pmcc_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic sleep_req,
    input wire logic [1:0] mode_sel,
    input wire logic stop_lp_reg,
    input wire logic irq_or_event,
    input wire logic [pmcc_pkg::EXT_LINES-1:0] external_event_line,
    input wire logic supply_monitor_output,
    input wire logic rtc_event,
    input wire logic two_wire_peripheral_req,
    input wire logic serial_port_peripheral_req,
    input wire logic [pmcc_pkg::WAKE_PINS-1:0] wakeup_pin,
    input wire logic external_reset_pin_n,
    input wire logic independent_watchdog_rst,
    input wire logic [1:0] clk_src_sel,
    input wire logic [7:0] sys_clk_mhz,
    input wire logic ext_clk_in,
    input wire logic fail_irq_en,
    input wire logic fail_clear,
    input wire logic [pmcc_pkg::PRE_W-1:0] ahb_pre,
    input wire logic [pmcc_pkg::PRE_W-1:0] apb_pre,
    input wire logic boot_pin,
    input wire logic boot_sel_opt,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic core_clk_en,
    output logic pll_en,
    output logic internal_rc_osc_en,
    output logic external_crystal_osc_en,
    output logic rtc_wdg_clk_en,
    output logic reg_on,
    output logic reg_lp,
    output logic standby_active,
    output logic rc_to_periph,
    output logic [1:0] sys_clk_src,
    output logic clk_fail_flag,
    output logic clk_fail_irq,
    output logic [pmcc_pkg::PRE_W-1:0] ahb_div,
    output logic [pmcc_pkg::PRE_W-1:0] apb_div,
    output logic [1:0] boot_src
);
    // Two-stage synchronisers for pin-side inputs
    localparam int NS = pmcc_pkg::EXT_LINES + pmcc_pkg::WAKE_PINS + 3;
    // Reset pin idles high, so its stages start at one: no false wake
    localparam logic [NS-1:0] SYNC_RST = {3'b001, {(NS-3){1'b0}}};
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;
    logic [NS-1:0] raw;
    assign raw = {ext_clk_in, boot_pin, external_reset_pin_n, wakeup_pin,
                  external_event_line};
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= SYNC_RST;
            s2_q <= SYNC_RST;
        end
        else if (ce)
        begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    logic [pmcc_pkg::EXT_LINES-1:0] evt_s;
    logic [pmcc_pkg::WAKE_PINS-1:0] wk_s;
    logic external_reset_pin_s;
    logic boot_s;
    logic ext_clk_s;
    assign evt_s = s2_q[pmcc_pkg::EXT_LINES-1:0];
    assign wk_s = s2_q[pmcc_pkg::EXT_LINES +: pmcc_pkg::WAKE_PINS];
    assign external_reset_pin_s = s2_q[NS-3];
    assign boot_s = s2_q[NS-2];
    assign ext_clk_s = s2_q[NS-1];

    // Power state machine and its helpers
    pmcc_pkg::pmcc_state_t st_q;
    pmcc_pkg::pmcc_state_t st_d;
    logic reg_lp_q;
    logic reg_lp_d;
    logic [pmcc_pkg::WAKE_PINS-1:0] wk_prev_q;
    logic [pmcc_pkg::SET_CNT_W-1:0] set_q;
    logic [pmcc_pkg::SET_CNT_W-1:0] set_d;
    logic stop_wake;
    logic stby_wake;
    logic periph_rc_req;
    logic [1:0] sel_q;
    logic [1:0] sel_d;

    assign stop_wake = (|evt_s) | supply_monitor_output | rtc_event
        | two_wire_peripheral_req | serial_port_peripheral_req;
    assign stby_wake = !external_reset_pin_s | independent_watchdog_rst
        | (|(wk_s & ~wk_prev_q)) | rtc_event;
    assign periph_rc_req = two_wire_peripheral_req
        | serial_port_peripheral_req;

    // Next state of the power sequencer
    always_comb
    begin
        st_d = st_q;
        reg_lp_d = reg_lp_q;
        set_d = set_q;
        unique case (st_q)
            pmcc_pkg::ST_RUN:
            begin
                if (sleep_req)
                begin
                    if (mode_sel == pmcc_pkg::MODE_STOP)
                    begin
                        st_d = pmcc_pkg::ST_STOP;
                        reg_lp_d = stop_lp_reg;
                    end
                    else if (mode_sel == pmcc_pkg::MODE_STANDBY)
                        st_d = pmcc_pkg::ST_STANDBY;
                    else
                        st_d = pmcc_pkg::ST_SLEEP;
                end
            end
            pmcc_pkg::ST_SLEEP:
            begin
                if (irq_or_event)
                    st_d = pmcc_pkg::ST_RUN;
            end
            pmcc_pkg::ST_STOP:
            begin
                if (stop_wake)
                begin
                    // Low-power regulator must settle back first
                    if (reg_lp_q)
                    begin
                        reg_lp_d = 1'b0;
                        set_d = '0;
                        st_d = pmcc_pkg::ST_STOP_WAKE;
                    end
                    else
                        st_d = pmcc_pkg::ST_RUN;
                end
            end
            pmcc_pkg::ST_STOP_WAKE:
            begin
                if (set_q == pmcc_pkg::SET_CNT_W'(
                        pmcc_pkg::REG_SETTLE_CYC - 1))
                    st_d = pmcc_pkg::ST_RUN;
                else
                    set_d = set_q + 1'b1;
            end
            pmcc_pkg::ST_STANDBY:
            begin
                if (stby_wake)
                    st_d = pmcc_pkg::ST_RUN;
            end
            default:
                st_d = pmcc_pkg::ST_RUN;
        endcase
    end

    // Power state registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= pmcc_pkg::ST_RUN;
            reg_lp_q <= 1'b0;
            set_q <= '0;
            wk_prev_q <= '0;
        end
        else if (ce)
        begin
            st_q <= st_d;
            reg_lp_q <= reg_lp_d;
            set_q <= set_d;
            wk_prev_q <= wk_s;
        end
    end

    // Clock and power enables per state
    logic in_stop;
    logic in_stby;
    assign in_stop = (st_q == pmcc_pkg::ST_STOP)
        || (st_q == pmcc_pkg::ST_STOP_WAKE);
    assign in_stby = (st_q == pmcc_pkg::ST_STANDBY);
    assign cpu_clk_en = (st_q == pmcc_pkg::ST_RUN);
    assign periph_clk_en = !in_stop && !in_stby;
    assign core_clk_en = !in_stop && !in_stby;
    assign pll_en = !in_stop && !in_stby
        && (sel_q == pmcc_pkg::SRC_PLL);
    assign internal_rc_osc_en = !in_stby
        && (!in_stop || rc_to_periph);
    assign external_crystal_osc_en = !in_stop && !in_stby
        && (sel_q != pmcc_pkg::SRC_RC);
    assign rtc_wdg_clk_en = 1'b1;
    assign reg_on = !in_stby;
    assign reg_lp = reg_lp_q;
    assign standby_active = in_stby;
    // RC clock reaches a peripheral only with a normal regulator
    assign rc_to_periph = (st_q == pmcc_pkg::ST_STOP) && periph_rc_req
        && !reg_lp_q;

    // Clock source selection with failure fallback
    logic fail_q;
    logic fail_d;
    logic mon_fail;
    logic mon_en;
    assign mon_en = (sel_q != pmcc_pkg::SRC_RC) && core_clk_en;

    pmcc_clk_monitor u_mon (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .enable(mon_en),
        .ext_clk_sync(ext_clk_s),
        .fail(mon_fail)
    );

    // Source choice, fail flag; a new failure wins over a clear
    always_comb
    begin
        sel_d = sel_q;
        fail_d = fail_q;
        if (fail_clear)
            fail_d = 1'b0;
        if (mon_fail)
        begin
            sel_d = pmcc_pkg::SRC_RC;
            fail_d = 1'b1;
        end
        else if (!fail_q && clk_src_sel != 2'h3)
            sel_d = clk_src_sel;
    end

    // Clock selection registers; RC after reset
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sel_q <= pmcc_pkg::SRC_RC;
            fail_q <= 1'b0;
        end
        else if (ce)
        begin
            sel_q <= sel_d;
            fail_q <= fail_d;
        end
    end

    assign sys_clk_src = sel_q;
    assign clk_fail_flag = fail_q;
    assign clk_fail_irq = fail_q && fail_irq_en;

    // Prescalers: raise divider until bus clock is within limit
    function automatic logic [pmcc_pkg::PRE_W-1:0] pmcc_limit(
        input logic [pmcc_pkg::PRE_W-1:0] pre,
        input logic [7:0] mhz);
        logic [pmcc_pkg::PRE_W-1:0] d;
        d = (pre == '0) ? pmcc_pkg::PRE_W'(1) : pre;
        for (int i = 0; i < 8; i++)
        begin
            if ((32'(mhz) + 32'(d) - 1) / 32'(d) > pmcc_pkg::BUS_MAX_MHZ
                && d != '1)
                d = d + 1'b1;
        end
        return d;
    endfunction

    logic [pmcc_pkg::PRE_W-1:0] ahb_q;
    logic [pmcc_pkg::PRE_W-1:0] apb_q;
    logic [1:0] boot_q;
    logic [1:0] boot_d;
    logic [1:0] boot_cnt_q;

    // Boot source from synchronised pin and option bit
    always_comb
    begin
        if (!boot_s)
            boot_d = pmcc_pkg::BOOT_FLASH;
        else if (boot_sel_opt)
            boot_d = pmcc_pkg::BOOT_SYSMEM;
        else
            boot_d = pmcc_pkg::BOOT_SRAM;
    end

    // Divider and boot registers; boot caught once the pin has synced
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ahb_q <= pmcc_pkg::PRE_W'(1);
            apb_q <= pmcc_pkg::PRE_W'(1);
            boot_q <= pmcc_pkg::BOOT_FLASH;
            boot_cnt_q <= 2'h0;
        end
        else if (ce)
        begin
            ahb_q <= pmcc_limit(ahb_pre, sys_clk_mhz);
            apb_q <= pmcc_limit(apb_pre, sys_clk_mhz);
            // Two edges fill the synchroniser; the third takes the pin
            if (boot_cnt_q != 2'h3)
            begin
                boot_cnt_q <= boot_cnt_q + 2'h1;
            end
            if (boot_cnt_q == 2'h2)
            begin
                boot_q <= boot_d;
            end
        end
    end

    assign ahb_div = ahb_q;
    assign apb_div = apb_q;
    assign boot_src = boot_q;
endmodule
`default_nettype wire

// ---- sim/pmcc_monitor.sv ----
// Port checker for the power mode and clock control block
`timescale 1ns/1ns
`default_nettype none
module pmcc_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic sleep_req,
    input wire logic [1:0] mode_sel,
    input wire logic stop_lp_reg,
    input wire logic irq_or_event,
    input wire logic independent_watchdog_rst,
    input wire logic fail_irq_en,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic core_clk_en,
    input wire logic pll_en,
    input wire logic external_crystal_osc_en,
    input wire logic reg_on,
    input wire logic reg_lp,
    input wire logic standby_active,
    input wire logic [1:0] sys_clk_src,
    input wire logic clk_fail_flag,
    input wire logic clk_fail_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Low-power request taken in the running state
    sequence req_s(logic [1:0] m);
        ce && cpu_clk_en && sleep_req && mode_sel == m;
    endsequence
    // Mode entry and exit
    sleep_in_a:
        assert property (req_s(2'h0) |=> !cpu_clk_en && periph_clk_en)
        else $error("sleep entry wrong");
    sleep_out_a:
        assert property (!cpu_clk_en && periph_clk_en && irq_or_event && ce
            |=> cpu_clk_en)
        else $error("sleep wake missed");
    stop_gate_a:
        assert property (req_s(2'h1)
            |=> !core_clk_en && !pll_en && !external_crystal_osc_en)
        else $error("stop left clocks on");
    stop_reg_a:
        assert property (req_s(2'h1) |=> reg_lp == $past(stop_lp_reg))
        else $error("stop regulator mode wrong");
    standby_in_a:
        assert property (req_s(2'h2) |=> !reg_on && standby_active && !pll_en)
        else $error("standby entry wrong");
    standby_out_a:
        assert property (!reg_on && ce && independent_watchdog_rst
            |=> reg_on && cpu_clk_en)
        else $error("standby wake missed");
    // Clock failure handling
    fallback_rc_a:
        assert property ($rose(clk_fail_flag) |-> sys_clk_src == 2'h0)
        else $error("no fallback to rc");
    fail_irq_a:
        assert property (clk_fail_irq == (clk_fail_flag && fail_irq_en))
        else $error("fail interrupt wrong");
    cover property (req_s(2'h0) ##[1:20] cpu_clk_en);
    cover property (req_s(2'h2));
    cover property ($rose(clk_fail_flag));
endmodule
bind pmcc_top pmcc_monitor u_check (.mclk, .rst, .ce, .sleep_req,
    .mode_sel, .stop_lp_reg, .irq_or_event, .independent_watchdog_rst,
    .fail_irq_en, .cpu_clk_en, .periph_clk_en, .core_clk_en, .pll_en,
    .external_crystal_osc_en, .reg_on, .reg_lp, .standby_active,
    .sys_clk_src, .clk_fail_flag, .clk_fail_irq);
`default_nettype wire

// ---- sim/pmcc_core_model.sv ----
// Behavioural core: asks for sleep, raises an interrupt while halted
`timescale 1ns/1ns
`default_nettype none
module pmcc_core_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cpu_clk_en,
    input wire logic sleep_go,
    input wire logic [7:0] irq_dly,
    output logic sleep_req,
    output logic irq_or_event
);
    logic [7:0] halt_q;
    // Sleep asked only while running; halted cycles counted
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sleep_req <= 1'b0;
            halt_q <= 8'h00;
        end
        else
        begin
            sleep_req <= sleep_go & cpu_clk_en;
            halt_q <= cpu_clk_en ? 8'h00 : halt_q + 8'h01;
        end
    end
    // Interrupt after the set delay, held until the core runs; 0 = never
    assign irq_or_event = (irq_dly != 8'h00) && (halt_q >= irq_dly);
endmodule
`default_nettype wire

// ---- sim/tb_pmcc_top.sv ----
// Self-checking bench for the power mode and clock control block
`timescale 1ns/1ns
`default_nettype none
module tb_pmcc_top;
    logic mclk, rst, ce, sleep_req, stop_lp_reg, irq_or_event, rtc_event;
    logic supply_monitor_output, two_wire_peripheral_req, fail_clear;
    logic serial_port_peripheral_req, external_reset_pin_n, ext_clk_in;
    logic independent_watchdog_rst, fail_irq_en, boot_pin, boot_sel_opt;
    logic cpu_clk_en, periph_clk_en, core_clk_en, pll_en, rtc_wdg_clk_en;
    logic internal_rc_osc_en, external_crystal_osc_en, reg_on, reg_lp;
    logic standby_active, rc_to_periph, clk_fail_flag, clk_fail_irq;
    logic sleep_go, ext_run;
    logic [1:0] mode_sel, clk_src_sel, wakeup_pin, sys_clk_src, boot_src;
    logic [15:0] external_event_line;
    logic [7:0] sys_clk_mhz, irq_dly;
    logic [3:0] ahb_pre, apb_pre, ahb_div, apb_div;
    int fail_count, n_compared, k;
    pmcc_top u_dut (.mclk, .rst, .ce, .sleep_req, .mode_sel, .stop_lp_reg,
        .irq_or_event, .external_event_line, .supply_monitor_output,
        .rtc_event, .two_wire_peripheral_req, .serial_port_peripheral_req,
        .wakeup_pin, .external_reset_pin_n, .independent_watchdog_rst,
        .clk_src_sel, .sys_clk_mhz, .ext_clk_in, .fail_irq_en, .fail_clear,
        .ahb_pre, .apb_pre, .boot_pin, .boot_sel_opt, .cpu_clk_en,
        .periph_clk_en, .core_clk_en, .pll_en, .internal_rc_osc_en,
        .external_crystal_osc_en, .rtc_wdg_clk_en, .reg_on, .reg_lp,
        .standby_active, .rc_to_periph, .sys_clk_src, .clk_fail_flag,
        .clk_fail_irq, .ahb_div, .apb_div, .boot_src);
    pmcc_core_model u_core (.mclk, .rst, .cpu_clk_en, .sleep_go, .irq_dly,
        .sleep_req, .irq_or_event);
    // Clocks: system clock and a slow external clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial
    begin
        ext_clk_in = 1'b0;
        forever
        begin
            repeat (5) @(posedge mclk);
            if (ext_run)
                ext_clk_in <= ~ext_clk_in;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic go(input logic [1:0] m);
        @(posedge mclk);
        mode_sel <= m;
        sleep_go <= 1'b1;
        @(posedge mclk);
        sleep_go <= 1'b0;
        cyc(3);
    endtask
    task automatic wrun(input int n);
        for (k = 0; k < n && cpu_clk_en !== 1'b1; k++)
            @(negedge mclk);
        chk(cpu_clk_en, 1'h1);
    endtask
    task automatic src_set(input int i, input logic v);
        @(posedge mclk);
        case (i)
            0: external_event_line[0] <= v;
            1: external_event_line[15] <= v;
            2: supply_monitor_output <= v;
            3: rtc_event <= v;
            4: two_wire_peripheral_req <= v;
            5: serial_port_peripheral_req <= v;
            6: independent_watchdog_rst <= v;
            7: external_reset_pin_n <= ~v;
            8: wakeup_pin[1] <= v;
            default: wakeup_pin[0] <= v;
        endcase
    endtask
    task automatic t_sleep(input logic [1:0] m);
        irq_dly = 8'h05;
        go(m);
        chk(cpu_clk_en, 1'h0);
        chk(periph_clk_en, 1'h1);
        wrun(20);
        irq_dly = 8'h00;
    endtask
    task automatic t_low(input logic [1:0] m, input logic lp, input int i);
        @(posedge mclk);
        stop_lp_reg <= lp;
        go(m);
        if (m == 2'h1)
        begin
            chk({core_clk_en, pll_en, external_crystal_osc_en}, 8'h00);
            chk(reg_lp, lp);
        end
        else
        begin
            chk({reg_on, internal_rc_osc_en, pll_en}, 8'h00);
            chk(standby_active, 1'h1);
        end
        chk(rtc_wdg_clk_en, 1'h1);
        src_set(i, 1'b1);
        wrun(40);
        chk({reg_on, reg_lp}, 8'h02);
        src_set(i, 1'b0);
    endtask
    task automatic t_periph(input int i, input logic lp);
        @(posedge mclk);
        stop_lp_reg <= lp;
        go(2'h1);
        src_set(i, 1'b1);
        @(negedge mclk);
        chk({rc_to_periph, reg_lp}, {6'h00, !lp, lp});
        @(negedge mclk);
        chk({reg_lp, internal_rc_osc_en}, {7'h00, !lp});
        wrun(40);
        chk(k[7:0], lp ? 8'(pmcc_pkg::REG_SETTLE_CYC) : 8'h00);
        src_set(i, 1'b0);
    endtask
    task automatic t_boot(input logic opt, input logic [1:0] exp);
        @(posedge mclk);
        boot_pin <= 1'b1;
        boot_sel_opt <= opt;
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        cyc(4);
        chk({sys_clk_src, cpu_clk_en}, 8'h01);
        chk(boot_src, exp);
    endtask
    task automatic t_fail();
        ext_run = 1'b1;
        @(posedge mclk);
        clk_src_sel <= pmcc_pkg::SRC_PLL;
        cyc(2);
        @(posedge mclk);
        clk_src_sel <= 2'h3;
        cyc(2);
        chk(sys_clk_src, pmcc_pkg::SRC_PLL);
        @(posedge mclk);
        clk_src_sel <= pmcc_pkg::SRC_XTAL;
        fail_irq_en <= 1'b1;
        cyc(200);
        chk({sys_clk_src, clk_fail_flag}, 8'h02);
        ext_run = 1'b0;
        for (k = 0; k < 300 && clk_fail_flag !== 1'b1; k++)
            @(negedge mclk);
        chk({sys_clk_src, clk_fail_flag, clk_fail_irq}, 8'h03);
        @(posedge mclk);
        fail_irq_en <= 1'b0;
        clk_src_sel <= pmcc_pkg::SRC_RC;
        @(negedge mclk);
        chk({clk_fail_flag, clk_fail_irq}, 8'h02);
        @(posedge mclk);
        fail_clear <= 1'b1;
        @(posedge mclk);
        fail_clear <= 1'b0;
        cyc(2);
        chk({clk_fail_flag, clk_fail_irq}, 8'h00);
    endtask
    task automatic t_div();
        @(posedge mclk);
        sys_clk_mhz <= 8'h60;
        ahb_pre <= 4'h1;
        apb_pre <= 4'h0;
        cyc(2);
        chk({ahb_div, apb_div}, 8'h22);
        @(posedge mclk);
        sys_clk_mhz <= 8'h30;
        ahb_pre <= 4'h4;
        apb_pre <= 4'h1;
        cyc(2);
        chk({ahb_div, apb_div}, 8'h41);
    endtask
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog against a hung run
    initial
    begin
        #300000;
        fail_count++;
        print_verdict();
    end
    // Main sequence
    initial
    begin
        {rst, ce, external_reset_pin_n, sys_clk_mhz} = {3'h7, 8'h08};
        {sleep_go, ext_run, stop_lp_reg, rtc_event} = 4'h0;
        {supply_monitor_output, two_wire_peripheral_req, fail_clear} = 3'h0;
        {serial_port_peripheral_req, independent_watchdog_rst} = 2'h0;
        {fail_irq_en, boot_pin, boot_sel_opt, wakeup_pin} = 5'h00;
        {mode_sel, clk_src_sel, external_event_line} = 20'h00000;
        {irq_dly, ahb_pre, apb_pre} = 16'h0011;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        cyc(4);
        chk({sys_clk_src, cpu_clk_en}, 8'h01);
        chk(boot_src, pmcc_pkg::BOOT_FLASH);
        t_sleep(2'h0);
        t_sleep(2'h3);
        for (int i = 0; i < 4; i++)
            t_low(2'h1, i[0], i);
        t_periph(4, 1'b1);
        t_periph(5, 1'b0);
        t_low(2'h2, 1'b0, 3);
        for (int i = 6; i < 10; i++)
            t_low(2'h2, 1'b0, i);
        t_fail();
        t_div();
        t_boot(1'b1, pmcc_pkg::BOOT_SYSMEM);
        t_boot(1'b0, pmcc_pkg::BOOT_SRAM);
        print_verdict();
    end
endmodule
`default_nettype wire
